// ==== mwc_pkg.sv ====
// constants and carrier types for the wake and checksum offload control bank
// assumes a 40 MHz system clock and a 32-bit apb register port
package mwc_pkg;

    // register word indices, byte address is four times the index
    localparam int ADDR_W = 8;
    localparam logic [5:0] IDX_FILTER = 6'h0B;
    localparam logic [5:0] IDX_WAKE_CSR = 6'h0C;
    localparam logic [5:0] IDX_CSUM_CR = 6'h0D;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h10;
    localparam logic [5:0] IDX_IRQ_CLR = 6'h11;
    localparam logic [5:0] IDX_IRQ_EN = 6'h12;

    // wake control and status field positions
    localparam int WCSR_PTR_REWIND = 31;
    localparam int WCSR_UCAST_EN = 9;
    localparam int WCSR_FRAME_SEEN = 6;
    localparam int WCSR_MAGIC_SEEN = 5;
    localparam int WCSR_FRAME_EN = 2;
    localparam int WCSR_MAGIC_EN = 1;

    // checksum offload control field positions
    localparam int CCR_TX_EN = 16;
    localparam int CCR_RX_MODE = 1;
    localparam int CCR_RX_EN = 0;

    // implemented bits and reset values
    localparam logic [31:0] WCSR_MASK = 32'h0000_0266;
    localparam logic [31:0] CCR_MASK = 32'h0001_0003;
    localparam logic [31:0] WCSR_RST = 32'h0000_0000;
    localparam logic [31:0] CCR_RST = 32'h0000_0000;

    // interrupt status layout
    localparam int IRQ_BITS = 3;
    localparam int IRQ_MAGIC = 0;
    localparam int IRQ_FRAME = 1;
    localparam int IRQ_UCAST = 2;

    // filter size and fixed receive checksum start
    localparam int FILTER_DEPTH = 8;
    localparam int CSUM_FIXED_HDR_BYTES = 14;

    // receive qualifiers from the mac receive path
    typedef struct packed {
        logic frame_ok;
        logic da_bit0;
        logic magic_ok;
        logic wake_frame_ok;
    } mwc_rx_evt_t;

    // steering of the checksum offload engines
    typedef struct packed {
        logic tx_en;
        logic rx_en;
        logic rx_l3_start;
    } mwc_csum_ctrl_t;

endpackage : mwc_pkg

// ==== mwc_filter_mem.sv ====
// wake frame filter storage, one write port and two registered read ports
// assumes writes and reads come from the same clock domain
`timescale 1ns/100ps
module mwc_filter_mem #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 32
) (
    input wire logic clk_sys,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_a_addr,
    output logic [WIDTH-1:0] rd_a_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_b_addr,
    output logic [WIDTH-1:0] rd_b_data
);

    // a single entry would leave the address ports without bits
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
        $error("filter store needs at least 2 entries of at least 1 bit");
    end

    logic [WIDTH-1:0] mem [DEPTH];

    // storage write and registered reads
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_a_data <= mem[rd_a_addr];
        rd_b_data <= mem[rd_b_addr];
    end

endmodule : mwc_filter_mem

// ==== mwc_sticky.sv ====
// sticky event flags, software clear, a set in the same cycle wins
// assumes set and clear are same-clock pulses
`timescale 1ns/100ps
module mwc_sticky #(
    parameter int WIDTH = 3
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    output logic [WIDTH-1:0] flags
);

    // an empty flag vector cannot be built
    if (WIDTH < 1) begin : g_bad_width
        $error("sticky flag width must be at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } mwc_sticky_st_t;

    mwc_sticky_st_t st_reg;
    mwc_sticky_st_t st_next;

    // per-bit clear then set
    always_comb begin
        st_next = st_reg;
        st_next.flags = (st_reg.flags & ~clr) | set;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flags = st_reg.flags;

endmodule : mwc_sticky

// ==== mwc_ctrl.sv ====
// wake-up control/status and checksum offload control registers on apb
// assumes mac receive qualifiers are single-cycle pulses on clk_sys
//
// Summary of operation
// - writing one to bit 31 rewinds the filter pointer; bit reads zero
// - unicast wake enable: frame with destination bit 0 clear ends power save
// - valid remote wake frame sets the frame-seen flag, bit 6
// - valid magic packet sets the magic-seen flag, bit 5
// - bit 2 enables wake frame detection through the programmed filter
// - bit 1 enables magic packet wake
// - checksum control bit 16 enables the transmit engine, else bypass
// - bit 1 clear starts receive checksum at byte 14, set at layer 3
// - checksum control bit 0 enables the receive engine, else bypass
// - filter is eight words through one location, pointer wraps after eighth
`timescale 1ns/100ps
module mwc_ctrl
    import mwc_pkg::*;
#(
    parameter int DEPTH = FILTER_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire mwc_rx_evt_t rx_evt,
    input wire logic power_save,
    input wire logic [$clog2(DEPTH)-1:0] filter_rd_idx,
    output logic [31:0] filter_rd_data,
    output logic wake_req,
    output logic magic_wake_en,
    output logic wake_frame_detect_en,
    output mwc_csum_ctrl_t csum_ctrl,
    output logic irq
);

    localparam int PTR_W = $clog2(DEPTH);

    // pointer wrap relies on a power-of-two depth, refused at elaboration
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("filter depth must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [PTR_W-1:0] fptr;
        logic magic_en;
        logic frame_en;
        logic ucast_en;
        logic magic_seen;
        logic frame_seen;
        logic tx_en;
        logic rx_en;
        logic rx_l3_start;
        logic [IRQ_BITS-1:0] irq_en;
        logic irq;
        logic wake_req;
    } mwc_st_t;

    mwc_st_t st_reg;
    mwc_st_t st_next;

    logic [5:0] idx;
    logic acc_first;
    logic done;
    logic wr_done;
    logic hit;
    logic ev_magic;
    logic ev_frame;
    logic ev_ucast;
    logic clr_wake;
    logic [31:0] mem_a_q;
    logic [31:0] wcsr_rd;
    logic [31:0] ccr_rd;
    logic [31:0] rd_word;
    logic [IRQ_BITS-1:0] irq_set;
    logic [IRQ_BITS-1:0] irq_clr;
    logic [IRQ_BITS-1:0] irq_flags;

    // apb phase decode, one wait state before every answer
    assign idx = paddr[ADDR_W-1:2];
    assign acc_first = psel & penable & ~st_reg.pready;
    assign done = psel & penable & st_reg.pready;
    assign wr_done = done & pwrite;
    assign hit = idx == IDX_FILTER || idx == IDX_WAKE_CSR || idx == IDX_CSUM_CR
        || idx == IDX_IRQ_STAT || idx == IDX_IRQ_CLR || idx == IDX_IRQ_EN;

    // qualified wake events
    assign ev_magic = rx_evt.magic_ok & st_reg.magic_en;
    assign ev_frame = rx_evt.wake_frame_ok & st_reg.frame_en;
    assign ev_ucast = rx_evt.frame_ok & ~rx_evt.da_bit0 & st_reg.ucast_en;

    // interrupt status events and write-one clears
    always_comb begin
        irq_set = '0;
        irq_set[IRQ_MAGIC] = ev_magic;
        irq_set[IRQ_FRAME] = ev_frame;
        irq_set[IRQ_UCAST] = ev_ucast;
        irq_clr = (wr_done && idx == IDX_IRQ_CLR) ? pwdata[IRQ_BITS-1:0] : '0;
    end

    mwc_sticky #(
        .WIDTH(IRQ_BITS)
    ) u_irq_stat (
        .clk_sys(clk_sys),
        .rst(rst),
        .set(irq_set),
        .clr(irq_clr),
        .flags(irq_flags)
    );

    // filter words, apb side walks the shared pointer
    mwc_filter_mem #(
        .DEPTH(DEPTH),
        .WIDTH(32)
    ) u_filter (
        .clk_sys(clk_sys),
        .wr_en(wr_done && idx == IDX_FILTER),
        .wr_addr(st_reg.fptr),
        .wr_data(pwdata),
        .rd_a_addr(st_reg.fptr),
        .rd_a_data(mem_a_q),
        .rd_b_addr(filter_rd_idx),
        .rd_b_data(filter_rd_data)
    );

    // readback words, unimplemented bits stay zero
    always_comb begin
        wcsr_rd = '0;
        wcsr_rd[WCSR_UCAST_EN] = st_reg.ucast_en;
        wcsr_rd[WCSR_FRAME_SEEN] = st_reg.frame_seen;
        wcsr_rd[WCSR_MAGIC_SEEN] = st_reg.magic_seen;
        wcsr_rd[WCSR_FRAME_EN] = st_reg.frame_en;
        wcsr_rd[WCSR_MAGIC_EN] = st_reg.magic_en;
        ccr_rd = '0;
        ccr_rd[CCR_TX_EN] = st_reg.tx_en;
        ccr_rd[CCR_RX_MODE] = st_reg.rx_l3_start;
        ccr_rd[CCR_RX_EN] = st_reg.rx_en;
        rd_word = '0;
        unique case (idx)
            IDX_FILTER: rd_word = mem_a_q;
            IDX_WAKE_CSR: rd_word = wcsr_rd;
            IDX_CSUM_CR: rd_word = ccr_rd;
            IDX_IRQ_STAT: rd_word = {{(32 - IRQ_BITS){1'b0}}, irq_flags};
            IDX_IRQ_EN: rd_word = {{(32 - IRQ_BITS){1'b0}}, st_reg.irq_en};
            default: rd_word = '0;
        endcase
    end

    assign clr_wake = wr_done && idx == IDX_WAKE_CSR;

    // next state of the whole bank
    always_comb begin
        st_next = st_reg;
        // answer phase
        if (acc_first) begin
            st_next.pready = 1'b1;
            st_next.pslverr = ~hit;
            st_next.prdata = pwrite ? '0 : rd_word;
        end else if (done) begin
            st_next.pready = 1'b0;
            st_next.pslverr = 1'b0;
            st_next.prdata = '0;
        end
        // filter pointer advances on each completed filter access and wraps
        if (done && idx == IDX_FILTER) begin
            st_next.fptr = st_reg.fptr + 1'b1;
        end
        // wake control write
        if (clr_wake) begin
            st_next.ucast_en = pwdata[WCSR_UCAST_EN];
            st_next.frame_en = pwdata[WCSR_FRAME_EN];
            st_next.magic_en = pwdata[WCSR_MAGIC_EN];
            if (pwdata[WCSR_FRAME_SEEN]) begin
                st_next.frame_seen = 1'b0;
            end
            if (pwdata[WCSR_MAGIC_SEEN]) begin
                st_next.magic_seen = 1'b0;
            end
            if (pwdata[WCSR_PTR_REWIND]) begin
                st_next.fptr = '0;
            end
        end
        // checksum control write
        if (wr_done && idx == IDX_CSUM_CR) begin
            st_next.tx_en = pwdata[CCR_TX_EN];
            st_next.rx_l3_start = pwdata[CCR_RX_MODE];
            st_next.rx_en = pwdata[CCR_RX_EN];
        end
        if (wr_done && idx == IDX_IRQ_EN) begin
            st_next.irq_en = pwdata[IRQ_BITS-1:0];
        end
        // received events win over a clear in the same cycle
        if (ev_frame) begin
            st_next.frame_seen = 1'b1;
        end
        if (ev_magic) begin
            st_next.magic_seen = 1'b1;
        end
        st_next.wake_req = power_save & (ev_magic | ev_frame | ev_ucast);
        st_next.irq = |(irq_flags & st_reg.irq_en);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign wake_req = st_reg.wake_req;
    assign magic_wake_en = st_reg.magic_en;
    assign wake_frame_detect_en = st_reg.frame_en;
    assign csum_ctrl = '{tx_en: st_reg.tx_en, rx_en: st_reg.rx_en,
        rx_l3_start: st_reg.rx_l3_start};
    assign irq = st_reg.irq;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_rewind;
        wr_done && idx == IDX_WAKE_CSR && pwdata[WCSR_PTR_REWIND] |=> st_reg.fptr == '0;
    endproperty
    a_rewind: assert property (p_rewind) else $error("pointer not rewound");

    property p_rewind_reads_zero;
        pready && !pwrite && idx == IDX_WAKE_CSR |-> !prdata[WCSR_PTR_REWIND];
    endproperty
    a_rewind_reads_zero: assert property (p_rewind_reads_zero)
        else $error("rewind bit read as one");

    property p_ucast_wake;
        st_reg.ucast_en && rx_evt.frame_ok && !rx_evt.da_bit0 && power_save |=> wake_req;
    endproperty
    a_ucast_wake: assert property (p_ucast_wake) else $error("unicast wake missed");

    property p_frame_seen;
        ev_frame |=> st_reg.frame_seen ##1 st_reg.frame_seen || $past(clr_wake);
    endproperty
    a_frame_seen: assert property (p_frame_seen) else $error("frame flag not set");

    property p_magic_seen;
        rx_evt.magic_ok && st_reg.magic_en |=> st_reg.magic_seen;
    endproperty
    a_magic_seen: assert property (p_magic_seen) else $error("magic flag not set");

    property p_frame_gate;
        $rose(st_reg.frame_seen) |-> $past(st_reg.frame_en) && $past(rx_evt.wake_frame_ok);
    endproperty
    a_frame_gate: assert property (p_frame_gate) else $error("frame flag without cause");

    property p_magic_gate;
        $rose(st_reg.magic_seen) |-> $past(st_reg.magic_en) && $past(rx_evt.magic_ok);
    endproperty
    a_magic_gate: assert property (p_magic_gate) else $error("magic flag without cause");

    property p_tx_en;
        wr_done && idx == IDX_CSUM_CR |=> csum_ctrl.tx_en == $past(pwdata[CCR_TX_EN]);
    endproperty
    a_tx_en: assert property (p_tx_en) else $error("tx engine enable wrong");

    property p_rx_mode;
        wr_done && idx == IDX_CSUM_CR |=> csum_ctrl.rx_l3_start == $past(pwdata[CCR_RX_MODE]);
    endproperty
    a_rx_mode: assert property (p_rx_mode) else $error("rx start mode wrong");

    property p_rx_en;
        wr_done && idx == IDX_CSUM_CR |=> csum_ctrl.rx_en == $past(pwdata[CCR_RX_EN]);
    endproperty
    a_rx_en: assert property (p_rx_en) else $error("rx engine enable wrong");

    property p_ptr_wrap;
        done && idx == IDX_FILTER && st_reg.fptr == PTR_W'(DEPTH - 1) |=> st_reg.fptr == '0;
    endproperty
    a_ptr_wrap: assert property (p_ptr_wrap) else $error("filter pointer did not wrap");

    property p_reserved;
        pready && !pwrite && idx == IDX_CSUM_CR |-> (prdata & ~CCR_MASK) == '0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit read as one");

    property p_sticky;
        st_reg.magic_seen && !clr_wake |=> st_reg.magic_seen;
    endproperty
    a_sticky: assert property (p_sticky) else $error("magic flag lost");

endmodule : mwc_ctrl

// ==== test_mac_wake_and_csum_offload_ctrl.sv ====
// self-checking testbench for the wake and checksum offload control bank
// assumes mwc_ctrl answers apb after one wait state and registers its outputs
`timescale 1ns/100ps
module test_mac_wake_and_csum_offload_ctrl
    import mwc_pkg::*;
;
    localparam logic [7:0] A_FLT = {IDX_FILTER, 2'b00};
    localparam logic [7:0] A_WCSR = {IDX_WAKE_CSR, 2'b00};
    localparam logic [7:0] A_CCR = {IDX_CSUM_CR, 2'b00};
    localparam logic [7:0] A_STAT = {IDX_IRQ_STAT, 2'b00};
    localparam logic [7:0] A_ICLR = {IDX_IRQ_CLR, 2'b00};
    localparam logic [7:0] A_IEN = {IDX_IRQ_EN, 2'b00};
    logic clk_sys;
    logic rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    mwc_rx_evt_t rx_evt;
    logic power_save;
    logic [2:0] filter_rd_idx;
    logic [31:0] filter_rd_data;
    logic wake_req;
    logic magic_wake_en;
    logic wake_frame_detect_en;
    mwc_csum_ctrl_t csum_ctrl;
    logic irq;
    int n_errors;
    int check_count;
    logic [31:0] rdat;
    logic rerr;

    // device under test
    mwc_ctrl #(.DEPTH(FILTER_DEPTH)) u_mwc_ctrl (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_evt(rx_evt), .power_save(power_save),
        .filter_rd_idx(filter_rd_idx), .filter_rd_data(filter_rd_data),
        .wake_req(wake_req), .magic_wake_en(magic_wake_en),
        .wake_frame_detect_en(wake_frame_detect_en), .csum_ctrl(csum_ctrl), .irq(irq)
    );

    // 40 mhz system clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer, entered and left right after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        // hold the request until pready is seen at an edge, watchdog bounds it
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask : rd

    // one receive qualifier pulse, then wake pulse and irq level
    task automatic evt(input logic [3:0] e, input logic exp_wake, input logic exp_irq);
        rx_evt <= mwc_rx_evt_t'(e);
        @(posedge clk_sys);
        rx_evt <= '0;
        #1;
        chk(32'(wake_req), 32'(exp_wake));
        @(posedge clk_sys);
        #1;
        chk(32'(irq), 32'(exp_irq));
        @(posedge clk_sys);
    endtask : evt

    task automatic t_reset();
        chk(32'(csum_ctrl), 32'h0);
        chk(32'(irq), 32'h0);
        rd(A_WCSR, WCSR_RST);
        rd(A_CCR, CCR_RST);
    endtask : t_reset

    task automatic t_csum();
        logic [31:0] wv [3] = '{32'h0001_0000, 32'h0000_0001, 32'h0000_0002};
        logic [2:0] cv [3] = '{3'b100, 3'b010, 3'b001};
        for (int i = 0; i < 3; i++) begin
            wr(A_CCR, wv[i]);
            rd(A_CCR, wv[i]);
            chk(32'(csum_ctrl), 32'(cv[i]));
        end
        wr(A_CCR, 32'hFFFF_FFFF);
        rd(A_CCR, 32'h0001_0003);
        chk(32'(csum_ctrl), 32'h7);
        wr(A_CCR, 32'h0);
        rd(A_CCR, 32'h0);
        chk(32'(csum_ctrl), 32'h0);
    endtask : t_csum

    task automatic t_wake_fields();
        wr(A_WCSR, 32'hFFFF_FFFF);
        rd(A_WCSR, 32'h0000_0206);
        chk(32'(magic_wake_en), 32'h1);
        wr(A_WCSR, 32'h0000_0004);
        rd(A_WCSR, 32'h0000_0004);
        chk(32'(magic_wake_en), 32'h0);
        chk(32'(wake_frame_detect_en), 32'h1);
    endtask : t_wake_fields

    task automatic t_events();
        wr(A_WCSR, 32'h0000_0206);
        wr(A_IEN, 32'h7);
        evt(4'h2, 1'b1, 1'b1);
        repeat (5) @(posedge clk_sys);
        rd(A_WCSR, 32'h0000_0226);
        rd(A_STAT, 32'h1);
        wr(A_WCSR, 32'h0000_0226);
        rd(A_WCSR, 32'h0000_0206);
        wr(A_ICLR, 32'h7);
        rd(A_STAT, 32'h0);
        chk(32'(irq), 32'h0);
        evt(4'h1, 1'b1, 1'b1);
        rd(A_WCSR, 32'h0000_0246);
        wr(A_ICLR, 32'h7);
        evt(4'hC, 1'b0, 1'b0);
        evt(4'h8, 1'b1, 1'b1);
        rd(A_STAT, 32'h4);
        wr(A_ICLR, 32'h7);
        power_save <= 1'b0;
        evt(4'h1, 1'b0, 1'b1);
        wr(A_ICLR, 32'h7);
        wr(A_WCSR, 32'h0000_0040);
        power_save <= 1'b1;
        evt(4'h2, 1'b0, 1'b0);
        evt(4'h1, 1'b0, 1'b0);
        evt(4'h8, 1'b0, 1'b0);
        rd(A_WCSR, 32'h0);
    endtask : t_events

    task automatic t_irq_mask();
        wr(A_IEN, 32'h0);
        wr(A_WCSR, 32'h0000_0002);
        evt(4'h2, 1'b1, 1'b0);
        rd(A_STAT, 32'h1);
        wr(A_IEN, 32'h1);
        rd(A_IEN, 32'h1);
        chk(32'(irq), 32'h1);
        wr(A_ICLR, 32'h1);
        rd(A_STAT, 32'h0);
        chk(32'(irq), 32'h0);
    endtask : t_irq_mask

    task automatic t_filter();
        wr(A_WCSR, 32'h8000_0000);
        rd(A_WCSR, 32'h0000_0020);
        for (int i = 0; i < 8; i++) begin
            wr(A_FLT, {8'hC3, 8'(i), 16'h5AA5});
        end
        for (int i = 0; i < 11; i++) begin
            rd(A_FLT, {8'hC3, 8'(i % 8), 16'h5AA5});
        end
        wr(A_WCSR, 32'h8000_0000);
        rd(A_FLT, 32'hC300_5AA5);
        filter_rd_idx <= 3'd5;
        repeat (2) @(posedge clk_sys);
        chk(filter_rd_data, 32'hC305_5AA5);
    endtask : t_filter

    task automatic t_unmapped();
        apb(1'b0, 8'h50, 32'h0);
        chk(32'(rerr), 32'h1);
        chk(rdat, 32'h0);
        apb(1'b1, 8'h50, 32'hFFFF_FFFF);
        chk(32'(rerr), 32'h1);
        wr(A_STAT, 32'hFFFF_FFFF);
        rd(A_STAT, 32'h0);
        rd(A_ICLR, 32'h0);
        chk(32'(rerr), 32'h0);
    endtask : t_unmapped

    // reset in mid-run clears enables, seen flags and status
    task automatic t_reset_mid();
        wr(A_CCR, 32'h0001_0003);
        wr(A_WCSR, 32'h0000_0002);
        evt(4'h2, 1'b1, 1'b1);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        rd(A_STAT, 32'h0);
    endtask : t_reset_mid

    // report counts and verdict, then stop
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        $display("[ERR] %0t ns: watchdog expired", $time);
        summarize();
    end

    // main sequence
    initial begin
        n_errors = 0;
        check_count = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        rx_evt = '0;
        power_save = 1'b1;
        filter_rd_idx = '0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_csum();
        t_wake_fields();
        t_events();
        t_irq_mask();
        t_filter();
        t_unmapped();
        t_reset_mid();
        summarize();
    end
endmodule : test_mac_wake_and_csum_offload_ctrl
